// ===== src/drive_shutdown_brake_sequencer.sv
// Shutdown, holding brake, regen supervision and supply fault sequencer
`timescale 1ns/1ps
`default_nettype none
module drive_shutdown_brake_sequencer #(
  parameter int DISABLE_DELAY_CYCLES = drive_seq_pkg::DISABLE_DELAY_CYCLES,
  parameter int RAMP_CYCLES = drive_seq_pkg::RAMP_CYCLES,
  parameter int BRAKE_TIMEOUT_CYCLES = drive_seq_pkg::BRAKE_TIMEOUT_CYCLES,
  parameter int DCLINK_CHECK_CYCLES = drive_seq_pkg::DCLINK_CHECK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_enable,
  input wire logic phase_lost,
  input wire logic peer_regen_active,
  input wire logic [15:0] measured_speed,
  input wire logic [10:0] dclink_volts,
  input wire logic [15:0] regen_power_avg,
  input wire logic [15:0] regen_power_peak,
  output logic stage_on,
  output logic brake_release,
  output logic regen_switch,
  output logic ready_to_operate_contact,
  output logic mains_fault_out,
  output logic current_limit,
  output logic [15:0] speed_setpoint
);
  localparam int TW = drive_seq_pkg::TMR_W;
  localparam int TICK = RAMP_CYCLES / drive_seq_pkg::RAMP_STEPS;

  if (BRAKE_TIMEOUT_CYCLES >= 2 ** TW || DISABLE_DELAY_CYCLES >= 2 ** TW ||
      DCLINK_CHECK_CYCLES > 65535 || DCLINK_CHECK_CYCLES < 1 || TICK < 1 || TICK > 65535)
  begin : g_chk
    $error("sequencer timing parameters out of range");
  end

  // Picks the level for the configured supply
  function automatic logic [10:0] volt_level(input logic [1:0] sel, input logic [10:0] l230,
                                             input logic [10:0] l400, input logic [10:0] l480);
    logic [10:0] v;
    v = l230;
    if (sel == drive_seq_pkg::SUPPLY_400) begin
      v = l400;
    end else if (sel == drive_seq_pkg::SUPPLY_480) begin
      v = l480;
    end
    return v;
  endfunction

  drive_seq_pkg::seq_state_t state;
  drive_seq_pkg::seq_state_t next_state;
  logic [6:0] ctrl;
  logic [15:0] cfg_setpoint;
  logic [15:0] lim_avg;
  logic [15:0] lim_peak;
  logic [10:0] uv_level;
  logic [7:0] fault_code;
  logic [7:0] next_fault;
  logic [TW-1:0] timer;
  logic [15:0] chk_cnt;
  logic [15:0] tick_cnt;
  logic [15:0] ramp_step;
  logic [4:0] trim;
  logic engaged;
  logic regen_cut;
  logic [2:0] pins_s;
  logic en_s;
  logic phase_s;
  logic peer_s;
  logic setup;
  logic access;
  logic wr;
  logic clear_wr;
  logic chk_strobe;
  logic ov_trip;
  logic uv_trip;
  logic pl_fault;
  logic over_power;
  logic stop_ok;
  logic delay_done;
  logic engage_next;
  logic [1:0] supply;
  logic [10:0] on_thr;
  logic [10:0] off_thr;
  logic [10:0] ov_level;
  logic [31:0] rd_word;
  logic addr_ok;

  // Enable, phase loss and peer regen arrive from pins
  pin_sync3 #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin({peer_regen_active, phase_lost, drive_enable}),
    .level(pins_s)
  );
  assign en_s = pins_s[0];
  assign phase_s = pins_s[1];
  assign peer_s = pins_s[2];

  // Bus phases; a write lands on the access edge with pready high
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign clear_wr = wr && paddr == drive_seq_pkg::FAULT_CLEAR_OFS && pwdata[0];
  assign addr_ok = paddr == drive_seq_pkg::CTRL_OFS || paddr == drive_seq_pkg::SETPOINT_OFS ||
                   paddr == drive_seq_pkg::REGEN_LIMIT_OFS || paddr == drive_seq_pkg::UV_LEVEL_OFS ||
                   paddr == drive_seq_pkg::STATUS_OFS || paddr == drive_seq_pkg::FAULT_CLEAR_OFS;

  // Regen thresholds follow supply selection plus the shared-link trim; the overvoltage level follows supply only
  assign supply = ctrl[drive_seq_pkg::CTRL_SUPPLY_LSB +: 2];
  assign on_thr = volt_level(supply, drive_seq_pkg::ON_230, drive_seq_pkg::ON_400,
                             drive_seq_pkg::ON_480) + 11'(trim);
  assign off_thr = volt_level(supply, drive_seq_pkg::OFF_230, drive_seq_pkg::OFF_400,
                              drive_seq_pkg::OFF_480) + 11'(trim);
  assign ov_level = volt_level(supply, drive_seq_pkg::OV_230, drive_seq_pkg::OV_400,
                               drive_seq_pkg::OV_480);

  // Fault detection; voltage faults at each periodic link check, phase loss at once
  assign chk_strobe = chk_cnt == 16'(DCLINK_CHECK_CYCLES - 1);
  assign ov_trip = chk_strobe && dclink_volts >= ov_level;
  assign uv_trip = chk_strobe && state != drive_seq_pkg::S_OFF && dclink_volts < uv_level;
  assign pl_fault = phase_s && ctrl[drive_seq_pkg::CTRL_PHASE_LOSS_RESPONSE];
  assign over_power = regen_power_avg > lim_avg || regen_power_peak > lim_peak;
  assign stop_ok = measured_speed <= drive_seq_pkg::STANDSTILL_RPM ||
                   timer >= TW'(BRAKE_TIMEOUT_CYCLES);
  assign delay_done = timer >= TW'(DISABLE_DELAY_CYCLES);
  assign engage_next = next_state == drive_seq_pkg::S_BRAKE && (engaged || stop_ok);

  // First fault is kept; a new one in the clearing cycle beats the clear
  always_comb begin
    next_fault = fault_code;
    if (clear_wr) begin
      next_fault = drive_seq_pkg::FAULT_NONE;
    end
    if (next_fault == drive_seq_pkg::FAULT_NONE) begin
      if (ov_trip) begin
        next_fault = drive_seq_pkg::FAULT_OVERVOLT;
      end else if (pl_fault) begin
        next_fault = drive_seq_pkg::FAULT_PHASE;
      end else if (uv_trip) begin
        next_fault = drive_seq_pkg::FAULT_UNDERVOLT;
      end
    end
  end

  // Sequencer; overvoltage always cuts the stage at once
  always_comb begin
    next_state = state;
    unique case (state)
      drive_seq_pkg::S_OFF: begin
        if (en_s && next_fault == drive_seq_pkg::FAULT_NONE) begin
          next_state = drive_seq_pkg::S_RUN;
        end
      end
      drive_seq_pkg::S_RUN: begin
        if (ov_trip) begin
          next_state = drive_seq_pkg::S_OFF;
        end else if (next_fault != drive_seq_pkg::FAULT_NONE) begin
          next_state = ctrl[drive_seq_pkg::CTRL_FAULTRESP] ? drive_seq_pkg::S_BRAKE
                                                            : drive_seq_pkg::S_OFF;
        end else if (!en_s) begin
          next_state = (ctrl[drive_seq_pkg::CTRL_BRAKE] || ctrl[drive_seq_pkg::CTRL_ENABLE_REMOVAL_RESPONSE])
                       ? drive_seq_pkg::S_BRAKE : drive_seq_pkg::S_OFF;
        end
      end
      drive_seq_pkg::S_BRAKE: begin
        if (ov_trip) begin
          next_state = drive_seq_pkg::S_OFF;
        end else if (ctrl[drive_seq_pkg::CTRL_BRAKE] ? (engaged && delay_done) : stop_ok) begin
          next_state = drive_seq_pkg::S_OFF;
        end
      end
      default: begin
        next_state = drive_seq_pkg::S_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= drive_seq_pkg::S_OFF;
      fault_code <= drive_seq_pkg::FAULT_NONE;
    end else begin
      state <= next_state;
      fault_code <= next_fault;
    end
  end

  // Shutdown timer restarts on every state change and saturates
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer <= '0;
      engaged <= 1'b0;
    end else begin
      engaged <= engage_next;
      if (next_state != state) begin
        timer <= '0;
      end else if (timer != '1) begin
        timer <= timer + 1'b1;
      end
    end
  end

  // Stage, brake and contact are registered; the brake releases one cycle after the stage comes on
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage_on <= 1'b0;
      brake_release <= 1'b0;
      ready_to_operate_contact <= 1'b0;
    end else begin
      stage_on <= next_state != drive_seq_pkg::S_OFF;
      // Needs stage already on, so the brake never lets go before torque exists
      brake_release <= ctrl[drive_seq_pkg::CTRL_BRAKE] && stage_on &&
                       next_state != drive_seq_pkg::S_OFF && !engage_next;
      ready_to_operate_contact <= next_fault == drive_seq_pkg::FAULT_NONE;
    end
  end

  // Phase loss in warning mode only limits current and flags the mains output
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mains_fault_out <= 1'b0;
      current_limit <= 1'b0;
    end else begin
      mains_fault_out <= phase_s;
      current_limit <= phase_s && !ctrl[drive_seq_pkg::CTRL_PHASE_LOSS_RESPONSE];
    end
  end

  // Ramp: fixed tick, step from the start value so zero comes within the ramp time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      speed_setpoint <= '0;
      ramp_step <= '0;
      tick_cnt <= '0;
    end else if (next_state == drive_seq_pkg::S_RUN) begin
      speed_setpoint <= cfg_setpoint;
      ramp_step <= (cfg_setpoint >> 8) + 16'h0001;
      tick_cnt <= '0;
    end else if (next_state == drive_seq_pkg::S_BRAKE) begin
      if (tick_cnt == 16'(TICK - 1)) begin
        tick_cnt <= '0;
        speed_setpoint <= speed_setpoint > ramp_step ? speed_setpoint - ramp_step : '0;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end else begin
      speed_setpoint <= '0;
      tick_cnt <= '0;
    end
  end

  // Link check period counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chk_cnt <= '0;
    end else begin
      chk_cnt <= chk_strobe ? '0 : chk_cnt + 16'h0001;
    end
  end

  // Regen chopper with hysteresis; a power overrun cuts it until cleared
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regen_cut <= 1'b0;
      regen_switch <= 1'b0;
    end else begin
      regen_cut <= over_power || (regen_cut && !clear_wr);
      if (over_power || regen_cut) begin
        regen_switch <= 1'b0;
      end else if (dclink_volts >= on_thr) begin
        regen_switch <= 1'b1;
      end else if (dclink_volts <= off_thr) begin
        regen_switch <= 1'b0;
      end
    end
  end

  // Shared link: an idle drive with a busy peer lowers its levels, a lone busy one raises them
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim <= '0;
    end else if (!ctrl[drive_seq_pkg::CTRL_SHARED]) begin
      trim <= '0;
    end else if (chk_strobe) begin
      if (peer_s && !regen_switch && trim != '0) begin
        trim <= trim - 5'h01;
      end else if (!peer_s && regen_switch && trim < drive_seq_pkg::TRIM_MAX) begin
        trim <= trim + 5'h01;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= drive_seq_pkg::CTRL_RESET;
      cfg_setpoint <= '0;
      lim_avg <= '1;
      lim_peak <= '1;
      uv_level <= drive_seq_pkg::UV_LEVEL_RESET;
    end else if (wr) begin
      if (paddr == drive_seq_pkg::CTRL_OFS) begin
        ctrl <= pwdata[6:0];
      end
      if (paddr == drive_seq_pkg::SETPOINT_OFS) begin
        cfg_setpoint <= pwdata[15:0];
      end
      if (paddr == drive_seq_pkg::REGEN_LIMIT_OFS) begin
        lim_avg <= pwdata[15:0];
        lim_peak <= pwdata[31:16];
      end
      if (paddr == drive_seq_pkg::UV_LEVEL_OFS) begin
        uv_level <= pwdata[10:0];
      end
    end
  end

  // Read mux; clear register and unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    unique case (paddr)
      drive_seq_pkg::CTRL_OFS: rd_word = {25'h0, ctrl};
      drive_seq_pkg::SETPOINT_OFS: rd_word = {16'h0, cfg_setpoint};
      drive_seq_pkg::REGEN_LIMIT_OFS: rd_word = {lim_peak, lim_avg};
      drive_seq_pkg::UV_LEVEL_OFS: rd_word = {21'h0, uv_level};
      drive_seq_pkg::STATUS_OFS: rd_word = {11'h0, trim, state, ready_to_operate_contact,
                                            brake_release, stage_on, regen_switch, regen_cut,
                                            current_limit, fault_code};
      default: rd_word = '0;
    endcase
  end

  // One wait-free access phase: answer is prepared in the setup cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      prdata <= (setup && !pwrite) ? rd_word : '0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_ov_check;
    ov_trip && fault_code == drive_seq_pkg::FAULT_NONE && !clear_wr;
  endsequence
  sequence s_ov_shutdown;
    fault_code == drive_seq_pkg::FAULT_OVERVOLT && !stage_on && !ready_to_operate_contact;
  endsequence

  property p_brake_unused;
    !ctrl[drive_seq_pkg::CTRL_BRAKE] |=> !brake_release;
  endproperty
  a_brake_unused: assert property (p_brake_unused) else $error("brake output used");
  property p_ramp_zero;
    state == drive_seq_pkg::S_BRAKE && timer > TW'(RAMP_CYCLES) |-> speed_setpoint == '0;
  endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("setpoint ramp too slow");
  property p_engage;
    state == drive_seq_pkg::S_BRAKE && next_state == drive_seq_pkg::S_BRAKE && stop_ok
      |=> !brake_release ##1 !brake_release;
  endproperty
  a_engage: assert property (p_engage) else $error("brake not engaged");
  property p_regen_on;
    $rose(regen_switch) |-> $past(dclink_volts) >= $past(on_thr) && !$past(regen_cut);
  endproperty
  a_regen_on: assert property (p_regen_on) else $error("regen on below threshold");
  property p_regen_cut;
    over_power |=> regen_cut && !regen_switch;
  endproperty
  a_regen_cut: assert property (p_regen_cut) else $error("regen not cut");
  property p_ov_trip;
    s_ov_check |=> s_ov_shutdown;
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("overvoltage shutdown missed");
  property p_contact_with_stage;
    ov_trip |=> !stage_on && !ready_to_operate_contact;
  endproperty
  a_contact_with_stage: assert property (p_contact_with_stage) else $error("contact late");
  property p_regen_off;
    $fell(regen_switch) |-> $past(dclink_volts) <= $past(off_thr) || $past(regen_cut) ||
      $past(over_power);
  endproperty
  a_regen_off: assert property (p_regen_off) else $error("regen off above threshold");
  property p_coast;
    state == drive_seq_pkg::S_RUN && !en_s && ctrl[2:0] == 3'h0 && next_fault == 8'h00
      |=> !stage_on;
  endproperty
  a_coast: assert property (p_coast) else $error("coast did not cut stage");
  property p_warn;
    phase_s && !ctrl[drive_seq_pkg::CTRL_PHASE_LOSS_RESPONSE] |=> current_limit && mains_fault_out;
  endproperty
  a_warn: assert property (p_warn) else $error("phase warning missing");
  property p_phase_err;
    pl_fault && fault_code == 8'h00 && !ov_trip && state == drive_seq_pkg::S_RUN &&
      ctrl[drive_seq_pkg::CTRL_FAULTRESP] |=> fault_code == drive_seq_pkg::FAULT_PHASE &&
      !ready_to_operate_contact && state == drive_seq_pkg::S_BRAKE;
  endproperty
  a_phase_err: assert property (p_phase_err) else $error("phase error response wrong");
  property p_brake_held;
    !stage_on |-> !brake_release;
  endproperty
  a_brake_held: assert property (p_brake_held) else $error("brake released while off");
  property p_fault_hold;
    fault_code != 8'h00 && !clear_wr |=> fault_code == $past(fault_code);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault code lost");
endmodule
`default_nettype wire

// ===== src/drive_seq_pkg.sv
// Constants for the drive shutdown, holding brake and regen sequencer
package drive_seq_pkg;
  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DISABLE_DELAY_MS = 100;
  localparam int DISABLE_DELAY_CYCLES = DISABLE_DELAY_MS * (CLK_HZ / 1000);
  localparam int RAMP_MS = 10;
  localparam int RAMP_CYCLES = RAMP_MS * (CLK_HZ / 1000);
  localparam int BRAKE_TIMEOUT_S = 5;
  localparam int BRAKE_TIMEOUT_CYCLES = BRAKE_TIMEOUT_S * CLK_HZ;
  localparam int DCLINK_CHECK_MS = 2;
  localparam int DCLINK_CHECK_CYCLES = DCLINK_CHECK_MS * (CLK_HZ / 1000);
  localparam int RAMP_STEPS = 256;
  localparam int TMR_W = 26;
  localparam logic [15:0] STANDSTILL_RPM = 16'h0005;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SETPOINT_OFS = 8'h04;
  localparam logic [7:0] REGEN_LIMIT_OFS = 8'h08;
  localparam logic [7:0] UV_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] FAULT_CLEAR_OFS = 8'h14;
  // Control field positions
  localparam int CTRL_BRAKE = 0;
  localparam int CTRL_ENABLE_REMOVAL_RESPONSE = 1;
  localparam int CTRL_FAULTRESP = 2;
  localparam int CTRL_PHASE_LOSS_RESPONSE = 3;
  localparam int CTRL_SUPPLY_LSB = 4;
  localparam int CTRL_SHARED = 6;
  localparam logic [6:0] CTRL_RESET = 7'h04;
  localparam logic [10:0] UV_LEVEL_RESET = 11'h0c8;
  // Supply selection codes
  localparam logic [1:0] SUPPLY_230 = 2'h0;
  localparam logic [1:0] SUPPLY_400 = 2'h1;
  localparam logic [1:0] SUPPLY_480 = 2'h2;
  // Regen and overvoltage levels in volts
  localparam logic [10:0] ON_230 = 11'h190;
  localparam logic [10:0] ON_400 = 11'h2d0;
  localparam logic [10:0] ON_480 = 11'h348;
  localparam logic [10:0] OFF_230 = 11'h17c;
  localparam logic [10:0] OFF_400 = 11'h2a8;
  localparam logic [10:0] OFF_480 = 11'h320;
  localparam logic [10:0] OV_230 = 11'h1c2;
  localparam logic [10:0] OV_400 = 11'h320;
  localparam logic [10:0] OV_480 = 11'h384;
  localparam logic [4:0] TRIM_MAX = 5'h1e;
  // Fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_OVERVOLT = 8'h02;
  localparam logic [7:0] FAULT_UNDERVOLT = 8'h05;
  localparam logic [7:0] FAULT_PHASE = 8'h13;
  // Sequencer states
  typedef enum logic [1:0] {
    S_OFF = 2'b00,
    S_RUN = 2'b01,
    S_BRAKE = 2'b10
  } seq_state_t;
endpackage

// ===== src/pin_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  if (W < 1) begin : g_chk
    $error("pin_sync3 needs W of at least 1");
  end

  // First stage feeds only the second, so metastability never reaches logic
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Per bit, accept the new value once two stages agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          level[i] <= ff3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/motor_model.sv
// Motor with holding brake driven by the sequencer
`timescale 1ns/1ps
`default_nettype none
module motor_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic stage_on,
  input wire logic brake_release,
  input wire logic [15:0] speed_setpoint,
  output logic [15:0] measured_speed
);
  // Tracks setpoint while powered with brake released; otherwise friction bleeds speed slowly
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      measured_speed <= 16'h0000;
    end else if (stage_on && brake_release) begin
      measured_speed <= speed_setpoint;
    end else if (measured_speed != 16'h0000) begin
      measured_speed <= measured_speed - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/drive_shutdown_brake_sequencer_tb.sv
// Bench for the shutdown, brake and regen sequencer
`timescale 1ns/1ps
`default_nettype none
module drive_shutdown_brake_sequencer_tb;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, stage_on, brake_release, regen_switch, contact, mains, climit;
  logic drive_enable = 0, phase_lost = 0, peer = 0;
  logic [15:0] speed, setpoint, p_avg = 16'h0000, p_peak = 16'h0000;
  logic [10:0] volts = 11'h12c;
  int n_fail = 0, checked = 0;
  // Short counts keep the run brief; checks below assume these values
  drive_shutdown_brake_sequencer #(.DISABLE_DELAY_CYCLES(200), .RAMP_CYCLES(512),
    .BRAKE_TIMEOUT_CYCLES(1000), .DCLINK_CHECK_CYCLES(16)) DUT (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_enable(drive_enable), .phase_lost(phase_lost), .peer_regen_active(peer),
    .measured_speed(speed), .dclink_volts(volts), .regen_power_avg(p_avg),
    .regen_power_peak(p_peak), .stage_on(stage_on), .brake_release(brake_release),
    .regen_switch(regen_switch), .ready_to_operate_contact(contact),
    .mains_fault_out(mains), .current_limit(climit), .speed_setpoint(setpoint));
  motor_model motor (.clk_sys(clk_sys), .reset_n(reset_n), .stage_on(stage_on),
    .brake_release(brake_release), .speed_setpoint(setpoint), .measured_speed(speed));
  // Clock
  always #50 clk_sys = ~clk_sys;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    checked++;
    if (got !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, x, got);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q & m);
  endtask
  task automatic t_regs;
    rd("ctrl", 8'h00, 32'h7f, 32'h04);
    rd("uv", 8'h0c, 32'h7ff, 32'h0c8);
    rd("unmapped", 8'h18, 32'hffffffff, 32'h0);
    chk("slverr", 1'b1, e);
  endtask
  // With brake: ramp under power, brake engages, stage drops last
  task automatic t_brake;
    apb(1'b1, 8'h04, 32'h0200);
    apb(1'b1, 8'h00, 32'h07);
    drive_enable <= 1'b1;
    cyc(8);
    chk("brk_rel", 1'b1, brake_release);
    drive_enable <= 1'b0;
    cyc(100);
    chk("stage_ramp", 1'b1, stage_on);
    chk("sp_ramp", 1'b1, setpoint < 16'h0200);
    cyc(520);
    chk("sp_zero", 16'h0, setpoint);
    chk("brk_eng", 1'b0, brake_release);
    chk("stage_off", 1'b0, stage_on);
  endtask
  task automatic t_coast;
    apb(1'b1, 8'h00, 32'h00);
    drive_enable <= 1'b1;
    cyc(8);
    chk("run", 1'b1, stage_on);
    chk("no_brk", 1'b0, brake_release);
    drive_enable <= 1'b0;
    cyc(8);
    chk("coast", 1'b0, stage_on);
  endtask
  // Regen hysteresis on the 400 V supply, then a power overrun
  task automatic t_regen;
    apb(1'b1, 8'h00, 32'h10);
    volts <= 11'h2cf;
    cyc(4);
    chk("rg719", 1'b0, regen_switch);
    volts <= 11'h2d0;
    cyc(4);
    chk("rg720", 1'b1, regen_switch);
    volts <= 11'h2a9;
    cyc(4);
    chk("rg681", 1'b1, regen_switch);
    volts <= 11'h2a8;
    cyc(4);
    chk("rg680", 1'b0, regen_switch);
    apb(1'b1, 8'h08, 32'h00ff0010);
    p_avg <= 16'h0020;
    volts <= 11'h2d0;
    cyc(6);
    chk("rg_cut", 1'b0, regen_switch);
    rd("rg_stat", 8'h10, 32'h200, 32'h200);
    p_avg <= 16'h0000;
    volts <= 11'h258;
    apb(1'b1, 8'h14, 32'h1);
    // A peak overrun alone must also hold regen off above switch-on
    p_peak <= 16'h0100;
    volts <= 11'h2d0;
    cyc(6);
    chk("rg_peak", 1'b0, regen_switch);
    p_peak <= 16'h0000;
    apb(1'b1, 8'h14, 32'h1);
  endtask
  // Shared link: lone busy drive trims up to the limit, idle one with busy peer trims down
  task automatic t_shared;
    apb(1'b1, 8'h00, 32'h50);
    volts <= 11'h2d0;
    cyc(520);
    rd("trim_up", 8'h10, 32'h1f0000, 32'h1e0000);
    peer <= 1'b1;
    volts <= 11'h258;
    cyc(520);
    rd("trim_down", 8'h10, 32'h1f0000, 32'h0);
    chk("rg_idle", 1'b0, regen_switch);
    peer <= 1'b0;
  endtask
  task automatic t_ov;
    apb(1'b1, 8'h00, 32'h14);
    drive_enable <= 1'b1;
    cyc(8);
    chk("rto_on", 1'b1, contact);
    volts <= 11'h320;
    cyc(24);
    chk("ov_stage", 1'b0, stage_on);
    chk("ov_rto", 1'b0, contact);
    rd("ov_code", 8'h10, 32'hff, 32'h02);
    volts <= 11'h258;
    drive_enable <= 1'b0;
    apb(1'b1, 8'h14, 32'h1);
    rd("cleared", 8'h10, 32'hff, 32'h00);
    // Raised undervoltage level catches the running drive at the next check
    drive_enable <= 1'b1;
    apb(1'b1, 8'h0c, 32'h2bc);
    cyc(24);
    rd("f05", 8'h10, 32'hff, 32'h05);
    chk("f05_rto", 1'b0, contact);
    chk("f05_stage", 1'b0, stage_on);
    apb(1'b1, 8'h0c, 32'h0c8);
    drive_enable <= 1'b0;
    cyc(8);
    apb(1'b1, 8'h14, 32'h1);
  endtask
  task automatic t_phase;
    drive_enable <= 1'b1;
    cyc(8);
    phase_lost <= 1'b1;
    cyc(8);
    chk("n05", 1'b1, climit);
    chk("mains", 1'b1, mains);
    chk("warn_run", 1'b1, stage_on);
    apb(1'b1, 8'h00, 32'h1c);
    rd("f19", 8'h10, 32'hc0ff, 32'h8013);
    chk("f19_rto", 1'b0, contact);
    phase_lost <= 1'b0;
    drive_enable <= 1'b0;
    cyc(1100);
    chk("f19_brk", 1'b0, brake_release);
  endtask
  // Main sequence
  initial begin
    cyc(8);
    reset_n <= 1'b1;
    cyc(1);
    t_regs();
    t_brake();
    t_coast();
    t_regen();
    t_shared();
    t_ov();
    t_phase();
    tally_and_finish();
  end
  // Hang guard
  initial begin
    cyc(20000);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
